/* common/dsp_ram_map_pkg.sv */
// Constants shared by the on-chip RAM map: block layout, spaces, register map.
// Assumes a 16-bit word address per space and one 100 MHz clock.
package dsp_ram_map_pkg;

  // Geometry of the on-chip RAM
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int BLOCK_WORDS = 8192;
  localparam int OFS_W = 13;
  localparam int NUM_BLOCKS = 9;
  localparam int NUM_DUAL = 2;
  localparam int BLK_W = 4;
  localparam int NUM_BUS = 4;

  // Block numbers
  localparam logic [3:0] BLK_DUAL0 = 4'h0;
  localparam logic [3:0] BLK_HOST = 4'h1;
  localparam logic [3:0] BLK_DATA_S0 = 4'h2;
  localparam logic [3:0] BLK_DATA_S1 = 4'h3;
  localparam logic [3:0] BLK_PROG0 = 4'h4;
  localparam logic [3:0] BLK_PROG_TOP0 = 4'h7;

  // Address landmarks
  localparam logic [15:0] RESERVED_END = 16'h007F;
  localparam logic [15:0] PROG_RAM_BASE = 16'h6000;
  localparam logic [15:0] BOOT_PROG_BASE = 16'hF800;
  localparam logic [2:0] DATA_EXT_LO = 3'h4;
  localparam logic [2:0] DATA_ROMMAP_LO = 3'h6;
  localparam logic [2:0] PROG_PAGE_BASE = 3'h3;

  // Address spaces
  typedef enum logic [1:0] {SPACE_DATA, SPACE_PROG, SPACE_IO} space_type;

  // Bus slots: write bus first, it has top priority on a block
  localparam int BUS_WR = 0;
  localparam int BUS_PF = 1;
  localparam int BUS_R1 = 2;
  localparam int BUS_R2 = 3;

  // Register port
  localparam logic [1:0] REG_MODE = 2'h0;
  localparam logic [1:0] REG_BANK = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam int MODE_DATA_ROM_MAP_BIT_POS = 3;
  localparam int MODE_RAM_OVERLAY_BIT_POS = 5;
  localparam int MODE_MPMC_POS = 6;
  localparam int BANK_BOOTDIS_POS = 4;
  localparam logic MPMC_RESET = 1'b0;
  localparam logic RAM_OVERLAY_BIT_RESET = 1'b0;
  localparam logic DATA_ROM_MAP_BIT_RESET = 1'b0;
  localparam logic BOOTDIS_RESET = 1'b0;

endpackage

/* rtl/ram_block.sv */
// One 8K x 16 RAM block with two registered read ports and one write port.
// Assumes the owner grants at most one access on a single-access block.
`timescale 1ns/1ps
`default_nettype none

module ram_block
  import dsp_ram_map_pkg::*;
#(
  parameter int WORDS = BLOCK_WORDS,
  parameter int AW = OFS_W
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Read port a
  input wire logic rd_a_en,
  input wire logic [AW-1:0] rd_a_addr,
  output logic [WORD_W-1:0] rd_a_data,
  // Read port b
  input wire logic rd_b_en,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [WORD_W-1:0] rd_b_data,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WORD_W-1:0] wr_data
);

  // Storage array
  logic [WORD_W-1:0] mem [WORDS];

  // Write port; a read of the same word in the same cycle sees the old value
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // Registered reads
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end
    else
    begin
      if (rd_a_en)
        rd_a_data <= mem[rd_a_addr];
      if (rd_b_en)
        rd_b_data <= mem[rd_b_addr];
    end
  end

endmodule

`default_nettype wire

/* rtl/addr_decoder.sv */
// Maps one bus address and space onto an on-chip block or the outside.
// Assumes mode bits are stable for the cycle of the access.
`timescale 1ns/1ps
`default_nettype none

module addr_decoder
  import dsp_ram_map_pkg::*;
(
  // Access
  input wire logic [ADDR_W-1:0] addr,
  input wire space_type space,
  // Mapping bits
  input wire logic overlay,
  input wire logic rom_map,
  input wire logic mp_mode,
  input wire logic boot_active,
  // Result
  output logic hit,
  output logic [BLK_W-1:0] blk,
  output logic [OFS_W-1:0] offset
);

  // Page number of the 8K window
  wire logic [2:0] page = addr[15:13];
  // Data space: four low blocks, top two only with the rom map bit
  wire logic data_low = (page < DATA_EXT_LO);
  wire logic data_top = (page >= DATA_ROMMAP_LO) && rom_map;
  // Program space: shadowed host RAM top, overlay, own program blocks
  wire logic prog_boot = boot_active && (addr >= BOOT_PROG_BASE);
  wire logic prog_ram_overlay_bit = overlay && (addr > RESERVED_END) && (addr < PROG_RAM_BASE);
  wire logic prog_own = !mp_mode && (addr >= PROG_RAM_BASE);
  // Program-only block number for a page from 3 upward
  wire logic [BLK_W-1:0] prog_blk = BLK_PROG0 + BLK_W'(page - PROG_PAGE_BASE);
  // Data-rom window blocks
  wire logic [BLK_W-1:0] top_blk = BLK_PROG_TOP0 + BLK_W'(page - DATA_ROMMAP_LO);

  assign offset = addr[OFS_W-1:0];

  // Decode per space; anything missed goes outside
  always_comb
  begin
    hit = 1'b0;
    blk = BLK_DUAL0;
    unique case (space)
      SPACE_DATA:
      begin
        // Low data window is on-chip after reset
        if (data_low)
        begin
          hit = 1'b1;
          blk = BLK_W'(page);
        end
        else if (data_top)
        begin
          hit = 1'b1;
          blk = top_blk;
        end
      end
      SPACE_PROG:
      begin
        if (prog_boot)
        begin
          hit = 1'b1;
          blk = BLK_HOST;
        end
        else if (prog_ram_overlay_bit)
        begin
          hit = 1'b1;
          blk = BLK_W'(page);
        end
        else if (prog_own)
        begin
          hit = 1'b1;
          blk = prog_blk;
        end
      end
      // I/O space never lands on chip
      SPACE_IO: hit = 1'b0;
      default: hit = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

/* rtl/dsp_ram_map.sv */
// On-chip RAM of the DSP subsystem with its four-bus address decoding.
// Assumes external spaces answer reads in the cycle after the request.
//
// What this block does
// - Nine 8K x16 blocks: two dual, seven single
// - 40K program, 16K dual data, 16K single data
// - Dual block takes two reads or read plus write
// - Different blocks serve accesses in same cycle
// - Two data reads, one fetch and one write per cycle
// - Fetch bus reads program space only
// - Write bus writes data and I/O space
// - Both read buses read data; second also I/O
// - I/O space goes to external peripherals
// - Data and program spaces can exchange data
// - After reset low data RAM data-only
// - After reset program RAM program-only
// - After reset low program range is external
// - Overlay bit maps data RAM into program
// - Normal map when boot disabled or mode bit
// - Boot mode shadows host RAM top into program
`timescale 1ns/1ps
`default_nettype none

module dsp_ram_map
  import dsp_ram_map_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [WORD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [WORD_W-1:0] reg_rdata,
  // Boot mode input from the host side, 1 selects the normal map
  input wire logic host_boot_mode_bit,
  // Program fetch bus
  input wire logic pf_req,
  input wire logic [ADDR_W-1:0] pf_addr,
  output logic pf_stall,
  output logic pf_valid,
  output logic [WORD_W-1:0] pf_rdata,
  // First data read bus
  input wire logic r1_req,
  input wire logic [ADDR_W-1:0] r1_addr,
  output logic r1_stall,
  output logic r1_valid,
  output logic [WORD_W-1:0] r1_rdata,
  // Second data read bus
  input wire logic r2_req,
  input wire logic [ADDR_W-1:0] r2_addr,
  input wire space_type r2_space,
  output logic r2_stall,
  output logic r2_valid,
  output logic [WORD_W-1:0] r2_rdata,
  // Data write bus
  input wire logic wr_req,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire space_type wr_space,
  input wire logic [WORD_W-1:0] wr_data,
  output logic wr_stall,
  // External program, data and I/O side, one request lane per bus
  output logic [NUM_BUS-1:0] ext_req,
  output logic [NUM_BUS*ADDR_W-1:0] ext_addr,
  output logic [NUM_BUS*2-1:0] ext_space,
  output logic ext_write,
  output logic [WORD_W-1:0] ext_wdata,
  input wire logic [NUM_BUS*WORD_W-1:0] ext_rdata
);

  // Mode bits held by software
  logic ram_overlay_bit;
  logic data_rom_map_bit;
  logic mpmc;
  logic boot_dis;
  // Host boot shadow is on only while both disables are clear
  wire logic boot_active = !boot_dis && !host_boot_mode_bit;

  // Per-bus request view
  logic [NUM_BUS-1:0] req;
  logic [ADDR_W-1:0] addr [NUM_BUS];
  space_type space [NUM_BUS];
  logic [NUM_BUS-1:0] hit;
  logic [BLK_W-1:0] blk [NUM_BUS];
  logic [OFS_W-1:0] ofs [NUM_BUS];

  // Grant results
  logic [NUM_BUS-1:0] grant;
  logic [NUM_BUS-1:0] port_b;

  // Block ports
  logic [NUM_BLOCKS-1:0] rd_a_en;
  logic [NUM_BLOCKS-1:0] rd_b_en;
  logic [NUM_BLOCKS-1:0] blk_wr_en;
  logic [OFS_W-1:0] rd_a_addr [NUM_BLOCKS];
  logic [OFS_W-1:0] rd_b_addr [NUM_BLOCKS];
  logic [WORD_W-1:0] rd_a_data [NUM_BLOCKS];
  logic [WORD_W-1:0] rd_b_data [NUM_BLOCKS];

  // Read return state, one slot per bus
  logic [NUM_BUS-1:0] ret_valid;
  logic [NUM_BUS-1:0] ret_ext;
  logic [NUM_BUS-1:0] ret_port_b;
  logic [BLK_W-1:0] ret_blk [NUM_BUS];
  logic [WORD_W-1:0] ret_data [NUM_BUS];

  // Number of accesses a block serves in one cycle
  function automatic int unsigned block_capacity(input logic [BLK_W-1:0] b);
    block_capacity = (b < BLK_W'(NUM_DUAL)) ? 2 : 1;
  endfunction

  // Gather bus signals; fetch and first read bus have fixed spaces
  assign req = {r2_req, r1_req, pf_req, wr_req};
  assign addr[BUS_WR] = wr_addr;
  assign addr[BUS_PF] = pf_addr;
  assign addr[BUS_R1] = r1_addr;
  assign addr[BUS_R2] = r2_addr;
  assign space[BUS_WR] = wr_space;
  assign space[BUS_PF] = SPACE_PROG;
  assign space[BUS_R1] = SPACE_DATA;
  assign space[BUS_R2] = r2_space;

  // One decoder per bus
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BUS; gb++)
    begin : g_dec
      addr_decoder u_dec (
        .addr(addr[gb]),
        .space(space[gb]),
        .overlay(ram_overlay_bit),
        .rom_map(data_rom_map_bit),
        .mp_mode(mpmc),
        .boot_active(boot_active),
        .hit(hit[gb]),
        .blk(blk[gb]),
        .offset(ofs[gb])
      );
    end
  endgenerate

  // Grant by priority; buses on different blocks never block each other
  always_comb
  begin
    int unsigned used;
    int unsigned readers;
    grant = '0;
    port_b = '0;
    used = 0;
    readers = 0;
    for (int b = 0; b < NUM_BUS; b++)
    begin
      used = 0;
      readers = 0;
      for (int j = 0; j < b; j++)
      begin
        // Count earlier grants on the same block
        if (grant[j] && blk[j] == blk[b])
        begin
          used = used + 1;
          if (j != BUS_WR)
            readers = readers + 1;
        end
      end
      if (req[b] && hit[b] && used < block_capacity(blk[b]))
      begin
        grant[b] = 1'b1;
        port_b[b] = (readers != 0);
      end
    end
  end

  // Stalls only for a lost fight over one block
  assign wr_stall = req[BUS_WR] && hit[BUS_WR] && !grant[BUS_WR];
  assign pf_stall = req[BUS_PF] && hit[BUS_PF] && !grant[BUS_PF];
  assign r1_stall = req[BUS_R1] && hit[BUS_R1] && !grant[BUS_R1];
  assign r2_stall = req[BUS_R2] && hit[BUS_R2] && !grant[BUS_R2];

  // Steer granted reads and the write onto block ports
  always_comb
  begin
    rd_a_en = '0;
    rd_b_en = '0;
    blk_wr_en = '0;
    for (int k = 0; k < NUM_BLOCKS; k++)
    begin
      rd_a_addr[k] = '0;
      rd_b_addr[k] = '0;
    end
    for (int b = BUS_PF; b < NUM_BUS; b++)
    begin
      if (grant[b] && port_b[b])
      begin
        rd_b_en[blk[b]] = 1'b1;
        rd_b_addr[blk[b]] = ofs[b];
      end
      else if (grant[b])
      begin
        rd_a_en[blk[b]] = 1'b1;
        rd_a_addr[blk[b]] = ofs[b];
      end
    end
    if (grant[BUS_WR])
      blk_wr_en[blk[BUS_WR]] = 1'b1;
  end

  // The nine RAM blocks, the first two dual-access
  genvar gk;
  generate
    for (gk = 0; gk < NUM_BLOCKS; gk++)
    begin : g_ram
      ram_block #(
        .WORDS(BLOCK_WORDS),
        .AW(OFS_W)
      ) u_ram (
        .ref_clk(ref_clk),
        .rst(rst),
        .rd_a_en(rd_a_en[gk]),
        .rd_a_addr(rd_a_addr[gk]),
        .rd_a_data(rd_a_data[gk]),
        .rd_b_en(rd_b_en[gk]),
        .rd_b_addr(rd_b_addr[gk]),
        .rd_b_data(rd_b_data[gk]),
        .wr_en(blk_wr_en[gk]),
        .wr_addr(ofs[BUS_WR]),
        .wr_data(wr_data)
      );
    end
  endgenerate

  // External lanes: anything not decoded on chip goes out
  generate
    for (gb = 0; gb < NUM_BUS; gb++)
    begin : g_ext
      assign ext_req[gb] = req[gb] && !hit[gb];
      assign ext_addr[gb*ADDR_W +: ADDR_W] = addr[gb];
      assign ext_space[gb*2 +: 2] = space[gb];
    end
  endgenerate
  assign ext_write = ext_req[BUS_WR];
  assign ext_wdata = wr_data;

  // Remember where each read will come back from
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ret_valid <= '0;
      ret_ext <= '0;
      ret_port_b <= '0;
      for (int b = 0; b < NUM_BUS; b++)
        ret_blk[b] <= '0;
    end
    else
    begin
      for (int b = BUS_PF; b < NUM_BUS; b++)
      begin
        ret_valid[b] <= grant[b] || ext_req[b];
        ret_ext[b] <= ext_req[b];
        ret_port_b[b] <= port_b[b];
        ret_blk[b] <= blk[b];
      end
    end
  end

  // Pick returned words from the block port or the outside
  always_comb
  begin
    for (int b = 0; b < NUM_BUS; b++)
    begin
      if (ret_ext[b])
        ret_data[b] = ext_rdata[b*WORD_W +: WORD_W];
      else if (ret_port_b[b])
        ret_data[b] = rd_b_data[ret_blk[b]];
      else
        ret_data[b] = rd_a_data[ret_blk[b]];
    end
  end

  // Read answers one cycle after the request
  assign pf_valid = ret_valid[BUS_PF];
  assign r1_valid = ret_valid[BUS_R1];
  assign r2_valid = ret_valid[BUS_R2];
  assign pf_rdata = ret_data[BUS_PF];
  assign r1_rdata = ret_data[BUS_R1];
  assign r2_rdata = ret_data[BUS_R2];

  // Mode and bank-switch registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ram_overlay_bit <= RAM_OVERLAY_BIT_RESET;
      data_rom_map_bit <= DATA_ROM_MAP_BIT_RESET;
      mpmc <= MPMC_RESET;
      boot_dis <= BOOTDIS_RESET;
    end
    else if (reg_wr && reg_addr == REG_MODE)
    begin
      ram_overlay_bit <= reg_wdata[MODE_RAM_OVERLAY_BIT_POS];
      data_rom_map_bit <= reg_wdata[MODE_DATA_ROM_MAP_BIT_POS];
      mpmc <= reg_wdata[MODE_MPMC_POS];
    end
    else if (reg_wr && reg_addr == REG_BANK)
      boot_dis <= reg_wdata[BANK_BOOTDIS_POS];
  end

  // Register read mux
  logic [WORD_W-1:0] next_rdata;
  always_comb
  begin
    next_rdata = '0;
    unique case (reg_addr)
      REG_MODE:
      begin
        next_rdata[MODE_RAM_OVERLAY_BIT_POS] = ram_overlay_bit;
        next_rdata[MODE_DATA_ROM_MAP_BIT_POS] = data_rom_map_bit;
        next_rdata[MODE_MPMC_POS] = mpmc;
      end
      REG_BANK: next_rdata[BANK_BOOTDIS_POS] = boot_dis;
      REG_STATUS: next_rdata[0] = boot_active;
      default: next_rdata = '0;
    endcase
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= '0;
  end

endmodule

`default_nettype wire

/* tb/dsp_ram_map_properties.sv */
// Port checks for the RAM map: read answers, routing, stalls.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module ram_map_checker
  import dsp_ram_map_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Program fetch bus
  input wire logic pf_req,
  input wire logic [ADDR_W-1:0] pf_addr,
  input wire logic pf_stall,
  input wire logic pf_valid,
  input wire logic [WORD_W-1:0] pf_rdata,
  // Data read buses
  input wire logic r1_req,
  input wire logic [ADDR_W-1:0] r1_addr,
  input wire logic r1_stall,
  input wire logic r1_valid,
  input wire logic r2_req,
  input wire logic [ADDR_W-1:0] r2_addr,
  input wire space_type r2_space,
  input wire logic r2_stall,
  input wire logic r2_valid,
  // Data write bus
  input wire logic wr_req,
  input wire space_type wr_space,
  input wire logic wr_stall,
  // External side
  input wire logic [NUM_BUS-1:0] ext_req,
  input wire logic ext_write,
  input wire logic [NUM_BUS*WORD_W-1:0] ext_rdata
);
  // One clock; checks rest while reset is high
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_pf_read_answer: assert property (pf_req && !pf_stall |=> pf_valid)
    else $error("fetch read gave no valid");
  a_r1_read_answer: assert property (r1_req && !r1_stall |=> r1_valid)
    else $error("first read gave no valid");
  a_r2_read_answer: assert property (r2_req && !r2_stall |=> r2_valid)
    else $error("second read gave no valid");
  a_io_read_out: assert property (r2_req && r2_space == SPACE_IO |->
    ext_req[3] && !r2_stall)
    else $error("I/O read kept on chip");
  a_io_write_out: assert property (wr_req && wr_space == SPACE_IO |->
    ext_req[0] && ext_write)
    else $error("I/O write kept on chip");
  a_write_never_waits: assert property (wr_req |-> !wr_stall)
    else $error("write bus stalled");
  a_low_prog_ext: assert property (pf_req && pf_addr < 16'h0080 |-> ext_req[1])
    else $error("low fetch not external");
  a_low_data_chip: assert property (r1_req && !r1_addr[15] |-> !ext_req[2])
    else $error("low data read went out");
  a_mid_data_ext: assert property (r1_req && r1_addr[15:14] == 2'b10 |->
    ext_req[2])
    else $error("external data read kept on chip");
  a_ext_data_pass: assert property (pf_req && ext_req[1] |=>
    pf_valid && pf_rdata == ext_rdata[31:16])
    else $error("external fetch word lost");
  a_dual_two_reads: assert property (r1_req && r2_req && !wr_req && !pf_req &&
    r2_space == SPACE_DATA && r1_addr[15:13] == r2_addr[15:13] && r1_addr[15:14] == 2'b00
    |-> !r1_stall && !r2_stall)
    else $error("dual block refused two reads");
endmodule

bind dsp_ram_map ram_map_checker chk_u (.ref_clk(ref_clk), .rst(rst),
  .pf_req(pf_req), .pf_addr(pf_addr), .pf_stall(pf_stall), .pf_valid(pf_valid),
  .pf_rdata(pf_rdata), .r1_req(r1_req), .r1_addr(r1_addr), .r1_stall(r1_stall),
  .r1_valid(r1_valid), .r2_req(r2_req), .r2_addr(r2_addr), .r2_space(r2_space),
  .r2_stall(r2_stall), .r2_valid(r2_valid), .wr_req(wr_req), .wr_space(wr_space),
  .wr_stall(wr_stall), .ext_req(ext_req), .ext_write(ext_write), .ext_rdata(ext_rdata));
`default_nettype wire

/* tb/ext_mem_model.sv */
// External program, data and I/O memory answering the four request lanes.
// Assumes a word is wanted the cycle after its lane requests it.
`timescale 1ns/1ps
`default_nettype none

module ext_mem_model
  import dsp_ram_map_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Request lanes from the RAM map
  input wire logic [NUM_BUS-1:0] ext_req,
  input wire logic [NUM_BUS*ADDR_W-1:0] ext_addr,
  input wire logic [NUM_BUS*2-1:0] ext_space,
  // Read words back to the RAM map
  output logic [NUM_BUS*WORD_W-1:0] ext_rdata
);
  logic [NUM_BUS-1:0] answer; // Lanes answering this cycle
  logic [NUM_BUS*WORD_W-1:0] word_q; // Last word of each lane

  // Latch a word per requesting lane; space folds into it
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NUM_BUS; i++)
    begin
      answer[i] <= ext_req[i] && !rst;
      if (ext_req[i])
        word_q[i*WORD_W +: WORD_W] <= ext_addr[i*ADDR_W +: ADDR_W] ^ 16'h5AC3 ^
          {ext_space[i*2 +: 2], 14'h0000};
    end
  end

  // Idle lanes show the inverse of the last word
  always_comb
  begin
    for (int i = 0; i < NUM_BUS; i++)
      ext_rdata[i*WORD_W +: WORD_W] = answer[i] ? word_q[i*WORD_W +: WORD_W] :
        ~word_q[i*WORD_W +: WORD_W];
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the RAM map: registers, maps, concurrency, random data.
// Assumes the external model answers every lane the cycle after it asks.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import dsp_ram_map_pkg::*;
  logic ref_clk = 1'b0; // 100 MHz clock
  logic rst = 1'b1; // Synchronous reset
  logic [1:0] reg_addr = 2'h0; // Register port
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic host_boot_mode_bit = 1'b1; // Normal map first
  logic pf_req = 1'b0, r1_req = 1'b0, r2_req = 1'b0, wr_req = 1'b0;
  logic [15:0] pf_addr = 16'h0000, r1_addr = 16'h0000, r2_addr = 16'h0000;
  logic [15:0] wr_addr = 16'h0000, wr_data = 16'h0000;
  space_type r2_space = SPACE_DATA, wr_space = SPACE_DATA;
  logic pf_stall, r1_stall, r2_stall, wr_stall, pf_valid, r1_valid, r2_valid;
  logic [15:0] pf_rdata, r1_rdata, r2_rdata;
  logic [3:0] ext_req;
  logic [63:0] ext_addr, ext_rdata;
  logic [15:0] ext_wdata, xw; // Outgoing write word and its mid-cycle sample
  logic [7:0] ext_space;
  logic [3:0] stl; // Stalls seen mid-cycle
  logic [2:0] gv; // Valids seen after the edge
  logic [15:0] gd [3]; // Read words seen after the edge
  logic [15:0] dm [int]; // Expected data words
  logic [15:0] a, d;
  int errors = 0, n_tests = 0, cyc = 0;

  always #5 ref_clk = ~ref_clk;

  dsp_ram_map dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_boot_mode_bit(host_boot_mode_bit), .pf_req(pf_req), .pf_addr(pf_addr),
    .pf_stall(pf_stall), .pf_valid(pf_valid), .pf_rdata(pf_rdata), .r1_req(r1_req),
    .r1_addr(r1_addr), .r1_stall(r1_stall), .r1_valid(r1_valid), .r1_rdata(r1_rdata),
    .r2_req(r2_req), .r2_addr(r2_addr), .r2_space(r2_space), .r2_stall(r2_stall),
    .r2_valid(r2_valid), .r2_rdata(r2_rdata), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_space(wr_space), .wr_data(wr_data), .wr_stall(wr_stall), .ext_req(ext_req),
    .ext_addr(ext_addr), .ext_space(ext_space), .ext_write(), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata));

  ext_mem_model ext_u (.ref_clk(ref_clk), .rst(rst), .ext_req(ext_req),
    .ext_addr(ext_addr), .ext_space(ext_space), .ext_rdata(ext_rdata));

  // Word the external model gives for an address and space
  function automatic logic [15:0] ext_val(input logic [15:0] ad, input space_type s);
    return ad ^ 16'h5AC3 ^ {s, 14'h0000};
  endfunction

  // Count a compare and report a mismatch
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Register write and read, one-cycle strobes
  task automatic rwr(input logic [1:0] ad, input logic [15:0] dt);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rrd(input logic [1:0] ad, input logic [15:0] e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, "register read");
    @(posedge ref_clk);
  endtask

  // One cycle of bus requests; en bits are pf, r1, r2, wr
  task automatic op(input logic [3:0] en, input logic [15:0] ap, a1, a2, aw,
    input space_type s2, sw, input logic [15:0] wd);
    {wr_req, r2_req, r1_req, pf_req} <= en;
    pf_addr <= ap;
    r1_addr <= a1;
    r2_addr <= a2;
    wr_addr <= aw;
    r2_space <= s2;
    wr_space <= sw;
    wr_data <= wd;
    #5 stl = {wr_stall, r2_stall, r1_stall, pf_stall};
    xw = ext_wdata;
    @(posedge ref_clk);
    {wr_req, r2_req, r1_req, pf_req} <= 4'h0;
    #1 gv = {r2_valid, r1_valid, pf_valid};
    gd = '{pf_rdata, r1_rdata, r2_rdata};
    @(posedge ref_clk);
  endtask

  // Single write, and single read on bus b (0 pf, 1 r1, 2 r2) with its check
  task automatic wr1(input logic [15:0] ad, input space_type s, input logic [15:0] dt);
    op(4'h8, ad, ad, ad, ad, SPACE_DATA, s, dt);
  endtask

  task automatic rd1(input int b, input logic [15:0] ad, input space_type s,
    input logic [15:0] e);
    op(4'(1 << b), ad, ad, ad, ad, s, SPACE_DATA, 16'h0000);
    chk({15'h0000, gv[b]}, 16'h0001, "read valid");
    chk(gd[b], e, "read word");
  endtask

  // Cut a hang short
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      $display("[ERR] %0t run too long", $time);
      report_and_stop();
    end
  end

  initial
  begin
    void'($urandom(32'h737C85E6));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rrd(2'h0, 16'h0000);
    rrd(2'h1, 16'h0000);
    rrd(2'h2, 16'h0000);
    rwr(2'h2, 16'hFFFF);
    rrd(2'h2, 16'h0000);
    rrd(2'h3, 16'h0000);
    $display("test registers done");
    wr1(16'h0200, SPACE_DATA, 16'h1234);
    rd1(0, 16'h0200, SPACE_PROG, ext_val(16'h0200, SPACE_PROG));
    rd1(1, 16'h0200, SPACE_DATA, 16'h1234);
    wr1(16'hC010, SPACE_PROG, 16'hBEEF);
    rd1(0, 16'hC010, SPACE_PROG, 16'hBEEF);
    rd1(1, 16'hC010, SPACE_DATA, ext_val(16'hC010, SPACE_DATA));
    rd1(1, 16'hA000, SPACE_DATA, ext_val(16'hA000, SPACE_DATA));
    rd1(2, 16'h0200, SPACE_IO, ext_val(16'h0200, SPACE_IO));
    wr1(16'h0033, SPACE_IO, 16'h0F0F);
    chk(xw, 16'h0F0F, "I/O write word");
    rwr(2'h0, 16'h0028);
    rrd(2'h0, 16'h0028);
    rd1(1, 16'hC010, SPACE_DATA, 16'hBEEF);
    rd1(0, 16'h0200, SPACE_PROG, 16'h1234);
    rd1(0, 16'h0010, SPACE_PROG, ext_val(16'h0010, SPACE_PROG));
    rwr(2'h0, 16'h0000);
    $display("test map done");
    wr1(16'h0100, SPACE_DATA, 16'hA1A1);
    wr1(16'h2100, SPACE_DATA, 16'hA2A2);
    wr1(16'h7000, SPACE_PROG, 16'hA3A3);
    op(4'hF, 16'h7000, 16'h0100, 16'h2100, 16'h4000, SPACE_DATA, SPACE_DATA, 16'h4444);
    chk({12'h000, stl}, 16'h0000, "four bus stall");
    chk({13'h0000, gv}, 16'h0007, "three valids");
    chk(gd[0], 16'hA3A3, "fetch word");
    chk(gd[1], 16'hA1A1, "first read word");
    chk(gd[2], 16'hA2A2, "second read word");
    op(4'h6, 16'h0000, 16'h0100, 16'h0100, 16'h0000, SPACE_DATA, SPACE_DATA, 16'h0000);
    chk({12'h000, stl}, 16'h0000, "dual two reads");
    chk(gd[2], 16'hA1A1, "dual second port word");
    op(4'hA, 16'h0000, 16'h0100, 16'h0000, 16'h0105, SPACE_DATA, SPACE_DATA, 16'h0505);
    chk({12'h000, stl}, 16'h0000, "dual read and write");
    chk(gd[1], 16'hA1A1, "read beside write");
    rd1(2, 16'h0105, SPACE_DATA, 16'h0505);
    op(4'h6, 16'h0000, 16'h4000, 16'h4001, 16'h0000, SPACE_DATA, SPACE_DATA, 16'h0000);
    chk({12'h000, stl}, 16'h0004, "single block conflict");
    chk(gd[1], 16'h4444, "single block word");
    $display("test concurrency done");
    repeat (40)
    begin
      a = 16'h0080 + 16'($urandom_range(32'h7F7F));
      d = 16'($urandom);
      dm[a] = d;
      wr1(a, SPACE_DATA, d);
      rd1(1 + $urandom_range(1), a, SPACE_DATA, dm[a]);
    end
    $display("test random done");
    rst <= 1'b1;
    host_boot_mode_bit <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rrd(2'h2, 16'h0001);
    wr1(16'h3900, SPACE_DATA, 16'h5151);
    rd1(0, 16'hF900, SPACE_PROG, 16'h5151);
    rwr(2'h1, 16'h0010);
    rrd(2'h2, 16'h0000);
    wr1(16'hF900, SPACE_PROG, 16'h6262);
    rd1(0, 16'hF900, SPACE_PROG, 16'h6262);
    rd1(1, 16'h3900, SPACE_DATA, 16'h5151);
    $display("test boot done");
    report_and_stop();
  end
endmodule
`default_nettype wire
